// File: dv/svw_host.sv
// Purpose: Host controller model driving the serial link and kick line
// Assumes: Mode 0, serial clock 6 ns period, idle low between frames
// Notes:   Undriven serial output reads as the inverse of its last level
`timescale 1ns/1ps

module svw_host (
	input  wire logic sys_clk,
	input  wire logic so_o,
	input  wire logic so_oe,
	output logic      sck,
	output logic      cs_n,
	output logic      si
);
	logic so_last;

	// Idle levels
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
		so_last = 1'b0;
	end

	// One select-low frame; clock may stall after bit pause_at
	task automatic frame(input logic [31:0] tx, input int nb, input int pause_at,
		output logic [7:0] rx);
		logic so_w;
		rx = 8'h00;
		@(posedge sys_clk);
		#1;
		cs_n = 1'b0;
		for (int i = 1; i <= nb; i++) begin
			si = tx[nb - i];
			#3;
			so_w = so_oe ? so_o : ~so_last;
			so_last = so_w;
			sck = 1'b1;
			if (i >= 9 && i <= 16) rx[16 - i] = so_w;
			#3;
			sck = 1'b0;
			if (i == pause_at) #20;
		end
		@(posedge sys_clk);
		#1;
		cs_n = 1'b1;
		si = ~si;
		repeat (8) @(posedge sys_clk);
		#1;
	endtask

	// Bare falling edge on the kick line
	task automatic kick();
		@(posedge sys_clk);
		#1;
		cs_n = 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
		cs_n = 1'b1;
		repeat (8) @(posedge sys_clk);
		#1;
	endtask
endmodule

// File: dv/svw_sva.sv
// Purpose: Port checker for the supervisor, watchdog and serial control
// Assumes: All checked outputs except SO_OE sit in the SYS_CLK domain; SO_OE is driven on SCK
// Notes:   Bound to svw_top at the foot of this file
`timescale 1ns/1ps

module svw_sva
	import svw_pkg::*;
#(
	parameter int unsigned POR_CYCLES = POR_HOLD_CYCLES
)(
	input wire logic       SYS_CLK,
	input wire logic       RESET_N,
	input wire logic       CLK_EN,
	input wire logic       SCK,
	input wire logic       CS_KICK_N,
	input wire logic       SI,
	input wire logic       SUPPLY_LOW,
	input wire logic       PROG_ENABLE_PIN,
	input wire logic [1:0] NV_CELL_SEL,
	input wire logic       SO_O,
	input wire logic       SO_OE,
	input wire logic       RESET_O,
	input wire logic       RESET_OE,
	input wire logic       NV_STORE_STB,
	input wire logic [1:0] NV_STORE_DATA,
	input wire logic       TRIP_SET_STB,
	input wire logic       TRIP_RESTORE_STB,
	input wire logic       TRIP_PROG_BUSY
);
	int unsigned good_q;

	// Cycles of supply good seen at the pin
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) good_q <= 0;
		else if (SUPPLY_LOW) good_q <= 0;
		else good_q <= good_q + 1;
	end

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RESET_N);

	// Steps of a threshold programming run
	sequence s_trip;
		TRIP_SET_STB || TRIP_RESTORE_STB;
	endsequence
	sequence s_pe_gone;
		$fell(PROG_ENABLE_PIN) ##1 !PROG_ENABLE_PIN[*7];
	endsequence

	property p_reset_od; RESET_O == !RESET_OE; endproperty
	property p_low_reset; (SUPPLY_LOW && CLK_EN)[*6] |-> RESET_OE; endproperty
	property p_por_hold; $fell(RESET_OE) |-> good_q >= POR_CYCLES; endproperty
	property p_so_release; CS_KICK_N |-> !SO_OE; endproperty
	property p_store_pulse; NV_STORE_STB |=> !NV_STORE_STB; endproperty
	property p_store_cs; NV_STORE_STB |-> CS_KICK_N && $past(CS_KICK_N, 3); endproperty
	property p_trip_pulse; s_trip |=> !TRIP_SET_STB && !TRIP_RESTORE_STB; endproperty
	property p_trip_busy; s_trip |=> TRIP_PROG_BUSY[*3]; endproperty
	property p_trip_pe; s_trip |-> PROG_ENABLE_PIN && $past(PROG_ENABLE_PIN, 6); endproperty
	property p_busy_drop; s_pe_gone |-> !TRIP_PROG_BUSY; endproperty

	a_reset_od: assert property (p_reset_od)
		else $error("reset pin level disagrees with enable");
	a_low_reset: assert property (p_low_reset)
		else $error("supply low without reset");
	a_por_hold: assert property (p_por_hold)
		else $error("reset released before hold time");
	a_so_release: assert property (p_so_release)
		else $error("serial output driven while deselected");
	a_store_pulse: assert property (p_store_pulse)
		else $error("store strobe longer than one cycle");
	a_store_cs: assert property (p_store_cs)
		else $error("store strobe without frame end");
	a_trip_pulse: assert property (p_trip_pulse)
		else $error("trip strobe longer than one cycle");
	a_trip_busy: assert property (p_trip_busy)
		else $error("programming busy not raised");
	a_trip_pe: assert property (p_trip_pe)
		else $error("trip strobe without program enable");
	a_busy_drop: assert property (p_busy_drop)
		else $error("programming busy stuck after enable low");
endmodule

bind svw_top svw_sva #(.POR_CYCLES(POR_CYCLES)) u_svw_sva (
	.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .CLK_EN(CLK_EN), .SCK(SCK),
	.CS_KICK_N(CS_KICK_N), .SI(SI), .SUPPLY_LOW(SUPPLY_LOW),
	.PROG_ENABLE_PIN(PROG_ENABLE_PIN), .NV_CELL_SEL(NV_CELL_SEL), .SO_O(SO_O),
	.SO_OE(SO_OE), .RESET_O(RESET_O), .RESET_OE(RESET_OE),
	.NV_STORE_STB(NV_STORE_STB), .NV_STORE_DATA(NV_STORE_DATA),
	.TRIP_SET_STB(TRIP_SET_STB), .TRIP_RESTORE_STB(TRIP_RESTORE_STB),
	.TRIP_PROG_BUSY(TRIP_PROG_BUSY)
);

// File: dv/svw_top_tb_top.sv
// Purpose: Self-checking bench for the supervisor, watchdog and serial control
// Assumes: Shortened hold, timeout and store counts
// Notes:   Nonvolatile cell modelled beside the design
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; $display("wrong value at %0t: got %h expected %h", $time, a, b); end end

module svw_top_tb_top
	import svw_pkg::*;
;
	localparam int POR = 50;
	localparam int WL  = 300;
	localparam int WM  = 200;
	localparam int WS  = 100;
	localparam int NVW = 20;
	int         num_errors = 0;
	int         checked = 0;
	int         n_store = 0;
	int         n_set = 0;
	int         n_rest = 0;
	int         n;
	int         lim [4] = '{WL, WM, WS, 0};
	logic       sys_clk = 1'b0;
	logic       reset_n, supply_low, prog_en, sck, cs_n, si;
	logic       so_o, so_oe, reset_o, reset_oe, nv_stb, set_stb, rest_stb, busy;
	logic [1:0] nv_data, nv_cell;

	svw_top #(.POR_CYCLES(POR), .WD_LONG_CYC(WL), .WD_MID_CYC(WM),
		.WD_SHORT_CYC(WS), .NV_WRITE_CYC(NVW)) u_svw_top (
		.SYS_CLK(sys_clk), .RESET_N(reset_n), .CLK_EN(1'b1), .SCK(sck),
		.CS_KICK_N(cs_n), .SI(si), .SUPPLY_LOW(supply_low),
		.PROG_ENABLE_PIN(prog_en), .NV_CELL_SEL(nv_cell), .SO_O(so_o),
		.SO_OE(so_oe), .RESET_O(reset_o), .RESET_OE(reset_oe),
		.NV_STORE_STB(nv_stb), .NV_STORE_DATA(nv_data), .TRIP_SET_STB(set_stb),
		.TRIP_RESTORE_STB(rest_stb), .TRIP_PROG_BUSY(busy));
	svw_host u_svw_host (.sys_clk(sys_clk), .so_o(so_o), .so_oe(so_oe),
		.sck(sck), .cs_n(cs_n), .si(si));

	// Clock, cell model and strobe counts
	always #2 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		if (nv_stb) nv_cell <= nv_data;
		n_store <= n_store + nv_stb;
		n_set <= n_set + set_stb;
		n_rest <= n_rest + rest_stb;
	end

	task automatic wait_cyc(input int c);
		repeat (c) @(posedge sys_clk);
		#1;
	endtask
	task automatic cmd(input logic [31:0] tx, input int nb);
		logic [7:0] rx;
		u_svw_host.frame(tx, nb, 0, rx);
	endtask
	task automatic rd(input logic [7:0] exp, input int pause_at);
		logic [7:0] rx;
		u_svw_host.frame({16'h0000, OP_READ_TIMEOUT, 8'h00}, 16, pause_at, rx);
		`CHK(rx, exp)
	endtask
	task automatic results();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// Hang guard
	initial begin
		wait_cyc(20000);
		num_errors++;
		results();
	end

	// Test sequence
	initial begin
		reset_n = 1'b0;
		supply_low = 1'b1;
		prog_en = 1'b0;
		nv_cell = 2'h3;
		wait_cyc(3);
		reset_n = 1'b1;
		supply_low = 1'b0;
		wait_cyc(POR - 2);
		`CHK(reset_oe, 1'b1)
		wait_cyc(14);
		`CHK(reset_oe, 1'b0)
		`CHK(reset_o, 1'b1)
		supply_low = 1'b1;
		wait_cyc(8);
		`CHK(reset_oe, 1'b1)
		supply_low = 1'b0;
		wait_cyc(30);
		supply_low = 1'b1;
		wait_cyc(3);
		supply_low = 1'b0;
		wait_cyc(POR - 2);
		`CHK(reset_oe, 1'b1)
		wait_cyc(14);
		`CHK(reset_oe, 1'b0)
		$display("test supply done");
		rd(8'h18, 3);
		cmd({OP_SET_TIMEOUT, 8'h10}, 16);
		`CHK(n_store, 0)
		cmd(OP_ENABLE_CHANGE, 8);
		cmd({OP_SET_TIMEOUT, 8'h10, 1'b0}, 17);
		`CHK(n_store, 0)
		cmd({OP_SET_TIMEOUT, 8'h10}, 16);
		`CHK(n_store, 1)
		`CHK(nv_data, 2'h2)
		rd(8'hFF, 0);
		wait_cyc(NVW);
		rd(8'h10, 0);
		cmd({OP_SET_TIMEOUT, 8'h08}, 16);
		`CHK(n_store, 1)
		cmd(OP_ENABLE_CHANGE, 8);
		cmd(OP_DISABLE_CHANGE, 8);
		cmd({OP_SET_TIMEOUT, 8'h08}, 16);
		`CHK(n_store, 1)
		reset_n = 1'b0;
		wait_cyc(3);
		reset_n = 1'b1;
		wait_cyc(8);
		rd(8'h10, 0);
		$display("test register done");
		prog_en = 1'b1;
		wait_cyc(8);
		cmd({OP_TRIP_GO, TRIP_ADDR, TRIP_ARG_SET}, 24);
		`CHK(n_set, 0)
		cmd({OP_TRIP_PREP, TRIP_ADDR, TRIP_ARG_SET}, 24);
		cmd({OP_TRIP_GO, TRIP_ADDR, TRIP_ARG_SET}, 24);
		`CHK(n_set, 1)
		`CHK(busy, 1'b1)
		prog_en = 1'b0;
		wait_cyc(10);
		`CHK(busy, 1'b0)
		prog_en = 1'b1;
		wait_cyc(8);
		cmd({OP_TRIP_PREP, TRIP_ADDR, TRIP_ARG_SET}, 24);
		cmd({OP_TRIP_GO, TRIP_ADDR, TRIP_ARG_RESTORE}, 24);
		`CHK(n_rest, 1)
		prog_en = 1'b0;
		wait_cyc(10);
		cmd({OP_TRIP_PREP, TRIP_ADDR, TRIP_ARG_SET}, 24);
		cmd({OP_TRIP_GO, TRIP_ADDR, TRIP_ARG_SET}, 24);
		`CHK(n_set, 1)
		$display("test threshold done");
		// Every timeout selection, expiry window and hold after expiry
		for (int s = 0; s < 4; s++) begin
			cmd(OP_ENABLE_CHANGE, 8);
			cmd({OP_SET_TIMEOUT, 3'h0, s[1:0], 3'h0}, 16);
			wait_cyc(NVW + 10);
			n = 0;
			while (reset_oe !== 1'b0 && n < 400) begin
				wait_cyc(1);
				n++;
			end
			u_svw_host.kick();
			n = 0;
			while (reset_oe !== 1'b1 && n < 400) begin
				wait_cyc(1);
				n++;
			end
			`CHK(n >= lim[s] - 10 && n <= lim[s] - 2, s != 3)
			if (s != 3) begin
				wait_cyc(POR - 4);
				`CHK(reset_oe, 1'b1)
				wait_cyc(16);
				`CHK(reset_oe, 1'b0)
			end
		end
		$display("test watchdog done");
		results();
	end
endmodule

// File: hw/svw_pkg.sv
// Purpose: Constants, types and timing counts for the supply supervisor, watchdog and serial control
// Assumes: SYS_CLK at 250 MHz; serial clock is a separate domain
package svw_pkg;

	// Clock rate and printed times
	localparam int unsigned SYS_CLK_KHZ       = 250000;
	localparam int unsigned POR_TIME_MS       = 200;
	localparam int unsigned WD_LONG_TIME_MS   = 1400;
	localparam int unsigned WD_MID_TIME_MS    = 600;
	localparam int unsigned WD_SHORT_TIME_MS  = 200;
	localparam int unsigned NV_WRITE_TIME_MS  = 10;

	// Derived cycle counts
	localparam int unsigned POR_HOLD_CYCLES   = POR_TIME_MS * SYS_CLK_KHZ;
	localparam int unsigned WD_LONG_CYCLES    = WD_LONG_TIME_MS * SYS_CLK_KHZ;
	localparam int unsigned WD_MID_CYCLES     = WD_MID_TIME_MS * SYS_CLK_KHZ;
	localparam int unsigned WD_SHORT_CYCLES   = WD_SHORT_TIME_MS * SYS_CLK_KHZ;
	localparam int unsigned NV_WRITE_CYCLES   = NV_WRITE_TIME_MS * SYS_CLK_KHZ;
	localparam int unsigned CNT_W             = 29;

	// Instruction opcodes
	localparam logic [7:0] OP_ENABLE_CHANGE   = 8'h06;
	localparam logic [7:0] OP_DISABLE_CHANGE  = 8'h04;
	localparam logic [7:0] OP_SET_TIMEOUT     = 8'h01;
	localparam logic [7:0] OP_READ_TIMEOUT    = 8'h05;
	localparam logic [7:0] OP_TRIP_PREP       = 8'h03;
	localparam logic [7:0] OP_TRIP_GO         = 8'h02;
	localparam logic [7:0] TRIP_ADDR          = 8'h00;
	localparam logic [7:0] TRIP_ARG_SET       = 8'h01;
	localparam logic [7:0] TRIP_ARG_RESTORE   = 8'h03;
	localparam logic [7:0] READ_BUSY_BYTE     = 8'hFF;

	// Frame lengths in bits
	localparam logic [4:0] LEN_ONE_BYTE       = 5'h08;
	localparam logic [4:0] LEN_TWO_BYTES      = 5'h10;
	localparam logic [4:0] LEN_THREE_BYTES    = 5'h18;
	localparam logic [4:0] LEN_MAX            = 5'h1F;
	localparam logic [4:0] LEN_READ_END       = 5'h0F;

	// Watchdog register fields and reset values
	localparam int unsigned WD_SEL_LO_POS     = 3;
	localparam int unsigned WD_SEL_HI_POS     = 4;
	localparam logic [1:0]  WD_SEL_1400MS     = 2'h0;
	localparam logic [1:0]  WD_SEL_600MS      = 2'h1;
	localparam logic [1:0]  WD_SEL_200MS      = 2'h2;
	localparam logic [1:0]  WD_SEL_OFF        = 2'h3;
	localparam logic [1:0]  WD_SEL_RST        = 2'h0;

	// Synchroniser order and reset levels: {program enable, supply low, select}
	localparam int unsigned SYNC_N            = 3;
	localparam int unsigned SYNC_CS           = 0;
	localparam int unsigned SYNC_LOW          = 1;
	localparam int unsigned SYNC_PE           = 2;
	localparam logic [2:0]  SYNC_RST          = 3'h3;

	typedef enum logic {SV_HOLD, SV_RUN} svw_sup_e;

	// Serial frame as seen when select rises
	typedef struct packed {
		logic [4:0] nbits;
		logic [7:0] b0;
		logic [7:0] b1;
		logic [7:0] b2;
	} svw_frame_s;

endpackage

// File: hw/svw_top.sv
// Purpose: Supply supervisor reset sequencer, watchdog and serial control slave
// Assumes: Comparator and programming cell are analog; their levels arrive as pins
// Notes:   Serial logic runs on SCK; SYS_CLK logic reads frame words only while select is high
`timescale 1ns/1ps

module svw_top
	import svw_pkg::*;
#(
	parameter int unsigned POR_CYCLES      = POR_HOLD_CYCLES,
	parameter int unsigned WD_LONG_CYC     = WD_LONG_CYCLES,
	parameter int unsigned WD_MID_CYC      = WD_MID_CYCLES,
	parameter int unsigned WD_SHORT_CYC    = WD_SHORT_CYCLES,
	parameter int unsigned NV_WRITE_CYC    = NV_WRITE_CYCLES
)(
	input  wire logic       SYS_CLK,
	input  wire logic       RESET_N,
	input  wire logic       CLK_EN,
	input  wire logic       SCK,
	input  wire logic       CS_KICK_N,
	input  wire logic       SI,
	input  wire logic       SUPPLY_LOW,
	input  wire logic       PROG_ENABLE_PIN,
	input  wire logic [1:0] NV_CELL_SEL,
	output logic            SO_O,
	output logic            SO_OE,
	output logic            RESET_O,
	output logic            RESET_OE,
	output logic            NV_STORE_STB,
	output logic [1:0]      NV_STORE_DATA,
	output logic            TRIP_SET_STB,
	output logic            TRIP_RESTORE_STB,
	output logic            TRIP_PROG_BUSY
);

	// Pin synchronisers and filtered levels
	logic [SYNC_N-1:0] sync1_q;
	logic [SYNC_N-1:0] sync2_q;
	logic [SYNC_N-1:0] sync3_q;
	logic [SYNC_N-1:0] filt_q;
	logic [SYNC_N-1:0] pin_raw;
	logic              cs_prev_q;
	logic              cs_fall;
	logic              cs_rise;

	// Control state
	logic              armed_q;
	logic              nv_loaded_q;
	logic [1:0]        wd_sel_q;
	logic              change_latch_q;
	logic              nv_busy_q;
	logic [CNT_W-1:0]  nv_cnt_q;
	logic [1:0]        nv_data_q;
	logic              nv_done;
	logic              nv_start;
	logic [7:0]        read_byte_q;
	logic              trip_armed_q;
	svw_sup_e          sup_q;
	logic [CNT_W-1:0]  hold_cnt_q;
	logic [CNT_W-1:0]  wd_cnt_q;
	logic [CNT_W-1:0]  wd_limit;
	logic              wd_expire;
	logic              commit;
	logic [2:0]        tog_sync_q;
	logic              tog_seen_q;
	logic              frame_new;

	// Frame decode
	logic              is_enable;
	logic              is_disable;
	logic              is_set_to;
	logic              is_trip_prep;
	logic              is_trip_set;
	logic              is_trip_restore;

	// Serial clock domain
	logic              fresh_q;
	logic              frame_tog_q;
	logic [7:0]        sh_q;
	logic [7:0]        sh_d;
	logic [4:0]        nbits_d;
	svw_frame_s        frame_q;
	logic              so_clr;
	logic [2:0]        rd_idx;
	logic [4:0]        rd_off;

	assign pin_raw = {PROG_ENABLE_PIN, SUPPLY_LOW, CS_KICK_N};

	// Three-stage synchroniser per pin, level accepted when stages two and three agree
	for (genvar i = 0; i < SYNC_N; i++) begin : g_sync
		always_ff @(posedge SYS_CLK or negedge RESET_N) begin
			if (!RESET_N) begin
				sync1_q[i] <= SYNC_RST[i];
				sync2_q[i] <= SYNC_RST[i];
				sync3_q[i] <= SYNC_RST[i];
				filt_q[i]  <= SYNC_RST[i];
			end else if (CLK_EN) begin
				sync1_q[i] <= pin_raw[i];
				sync2_q[i] <= sync1_q[i];
				sync3_q[i] <= sync2_q[i];
				if (sync2_q[i] == sync3_q[i]) begin
					filt_q[i] <= sync3_q[i];
				end
			end
		end
	end

	// Select edge detection on the filtered level
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			cs_prev_q <= 1'b1;
		end else if (CLK_EN) begin
			cs_prev_q <= filt_q[SYNC_CS];
		end
	end

	assign cs_fall = cs_prev_q & ~filt_q[SYNC_CS];
	assign cs_rise = ~cs_prev_q & filt_q[SYNC_CS];

	// Serial frames count only after a first falling select edge
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			armed_q <= 1'b0;
		end else if (CLK_EN) begin
			if (cs_fall) begin
				armed_q <= 1'b1;
			end
		end
	end

	// Frame toggle crossing into this domain, accepted when stages two and three agree
	// A select pulse with no serial clock is a bare kick and must not commit a stale frame
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			tog_sync_q <= 3'h0;
			tog_seen_q <= 1'b0;
		end else if (CLK_EN) begin
			tog_sync_q <= {tog_sync_q[1:0], frame_tog_q};
			if (commit) begin
				tog_seen_q <= tog_sync_q[2];
			end
		end
	end

	assign frame_new = (tog_sync_q[1] == tog_sync_q[2]) && (tog_sync_q[2] != tog_seen_q);
	assign commit    = cs_rise & armed_q & frame_new;

	// Exact bit counts at select rise decide which frame is acted on
	always_comb begin
		is_enable       = (frame_q.nbits == LEN_ONE_BYTE) && (frame_q.b0 == OP_ENABLE_CHANGE);
		is_disable      = (frame_q.nbits == LEN_ONE_BYTE) && (frame_q.b0 == OP_DISABLE_CHANGE);
		is_set_to       = (frame_q.nbits == LEN_TWO_BYTES) && (frame_q.b0 == OP_SET_TIMEOUT);
		is_trip_prep    = (frame_q.nbits == LEN_THREE_BYTES) && (frame_q.b0 == OP_TRIP_PREP)
			&& (frame_q.b1 == TRIP_ADDR) && (frame_q.b2 == TRIP_ARG_SET);
		is_trip_set     = (frame_q.nbits == LEN_THREE_BYTES) && (frame_q.b0 == OP_TRIP_GO)
			&& (frame_q.b1 == TRIP_ADDR) && (frame_q.b2 == TRIP_ARG_SET);
		is_trip_restore = (frame_q.nbits == LEN_THREE_BYTES) && (frame_q.b0 == OP_TRIP_GO)
			&& (frame_q.b1 == TRIP_ADDR) && (frame_q.b2 == TRIP_ARG_RESTORE);
	end

	// Change latch: enable wins over the clear at write completion
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			change_latch_q <= 1'b0;
		end else if (CLK_EN) begin
			if (commit && is_enable) begin
				change_latch_q <= 1'b1;
			end else if (commit && is_disable) begin
				change_latch_q <= 1'b0;
			end else if (nv_done) begin
				change_latch_q <= 1'b0;
			end
		end
	end

	assign nv_start = commit & is_set_to & change_latch_q & ~nv_busy_q;
	assign nv_done  = nv_busy_q && (nv_cnt_q == CNT_W'(NV_WRITE_CYC - 1));

	// Nonvolatile store cycle: strobe the cell, then wait out the write time
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			nv_busy_q     <= 1'b0;
			nv_cnt_q      <= '0;
			nv_data_q     <= WD_SEL_RST;
			NV_STORE_STB  <= 1'b0;
			NV_STORE_DATA <= WD_SEL_RST;
		end else if (CLK_EN) begin
			NV_STORE_STB <= nv_start;
			if (nv_start) begin
				nv_busy_q     <= 1'b1;
				nv_cnt_q      <= '0;
				nv_data_q     <= {frame_q.b1[WD_SEL_HI_POS], frame_q.b1[WD_SEL_LO_POS]};
				NV_STORE_DATA <= {frame_q.b1[WD_SEL_HI_POS], frame_q.b1[WD_SEL_LO_POS]};
			end else if (nv_done) begin
				nv_busy_q <= 1'b0;
				nv_cnt_q  <= '0;
			end else if (nv_busy_q) begin
				nv_cnt_q <= nv_cnt_q + 1'b1;
			end
		end
	end

	// Select bits: caught from the cell after reset release, updated when a store ends
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			nv_loaded_q <= 1'b0;
			wd_sel_q    <= WD_SEL_RST;
		end else if (CLK_EN) begin
			if (!nv_loaded_q) begin
				nv_loaded_q <= 1'b1;
				wd_sel_q    <= NV_CELL_SEL;
			end else if (nv_done) begin
				wd_sel_q <= nv_data_q;
			end
		end
	end

	// Read image, refreshed only while select is high so the serial side sees it still
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			read_byte_q <= 8'h00;
		end else if (CLK_EN) begin
			if (filt_q[SYNC_CS]) begin
				if (nv_busy_q) begin
					read_byte_q <= READ_BUSY_BYTE;
				end else begin
					read_byte_q                <= 8'h00;
					read_byte_q[WD_SEL_HI_POS] <= wd_sel_q[1];
					read_byte_q[WD_SEL_LO_POS] <= wd_sel_q[0];
				end
			end
		end
	end

	// Threshold programming: preparation frame must directly precede the go frame
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			trip_armed_q     <= 1'b0;
			TRIP_SET_STB     <= 1'b0;
			TRIP_RESTORE_STB <= 1'b0;
			TRIP_PROG_BUSY   <= 1'b0;
		end else if (CLK_EN) begin
			TRIP_SET_STB     <= commit & trip_armed_q & is_trip_set & filt_q[SYNC_PE];
			TRIP_RESTORE_STB <= commit & trip_armed_q & is_trip_restore & filt_q[SYNC_PE];
			if (commit) begin
				trip_armed_q <= is_trip_prep;
			end
			if (commit && trip_armed_q && filt_q[SYNC_PE] && (is_trip_set || is_trip_restore)) begin
				TRIP_PROG_BUSY <= 1'b1;
			end else if (!filt_q[SYNC_PE]) begin
				TRIP_PROG_BUSY <= 1'b0;
			end
		end
	end

	// Timeout length from the select bits
	always_comb begin
		case (wd_sel_q)
			WD_SEL_1400MS: wd_limit = CNT_W'(WD_LONG_CYC - 1);
			WD_SEL_600MS:  wd_limit = CNT_W'(WD_MID_CYC - 1);
			WD_SEL_200MS:  wd_limit = CNT_W'(WD_SHORT_CYC - 1);
			default:       wd_limit = '0;
		endcase
	end

	assign wd_expire = (sup_q == SV_RUN) && (wd_sel_q != WD_SEL_OFF) && (wd_cnt_q == wd_limit);

	// Watchdog count, cleared by a kick, while off, and while reset is held
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			wd_cnt_q <= '0;
		end else if (CLK_EN) begin
			if ((sup_q != SV_RUN) || cs_fall || (wd_sel_q == WD_SEL_OFF) || wd_expire) begin
				wd_cnt_q <= '0;
			end else begin
				wd_cnt_q <= wd_cnt_q + 1'b1;
			end
		end
	end

	// Reset sequencer: hold until supply good for the full period
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			sup_q      <= SV_HOLD;
			hold_cnt_q <= '0;
			RESET_OE   <= 1'b1;
			RESET_O    <= 1'b0;
		end else if (CLK_EN) begin
			case (sup_q)
				SV_HOLD: begin
					if (filt_q[SYNC_LOW]) begin
						hold_cnt_q <= '0;
					end else if (hold_cnt_q == CNT_W'(POR_CYCLES - 1)) begin
						hold_cnt_q <= '0;
						sup_q      <= SV_RUN;
						RESET_OE   <= 1'b0;
						RESET_O    <= 1'b1;
					end else begin
						hold_cnt_q <= hold_cnt_q + 1'b1;
					end
				end
				SV_RUN: begin
					if (filt_q[SYNC_LOW] || wd_expire) begin
						sup_q      <= SV_HOLD;
						hold_cnt_q <= '0;
						RESET_OE   <= 1'b1;
						RESET_O    <= 1'b0;
					end
				end
				default: begin
					sup_q    <= SV_HOLD;
					RESET_OE <= 1'b1;
					RESET_O  <= 1'b0;
				end
			endcase
		end
	end

	// First rising serial edge after select falls starts a new frame
	always_ff @(posedge SCK or posedge CS_KICK_N) begin
		if (CS_KICK_N) begin
			fresh_q <= 1'b1;
		end else begin
			fresh_q <= 1'b0;
		end
	end

	// Toggles on the first bit of each frame; stable long before select rises
	always_ff @(posedge SCK or negedge RESET_N) begin
		if (!RESET_N) begin
			frame_tog_q <= 1'b0;
		end else if (fresh_q) begin
			frame_tog_q <= ~frame_tog_q;
		end
	end

	// Next shift value and bit count, MSB arrives first
	always_comb begin
		sh_d    = fresh_q ? {7'h00, SI} : {sh_q[6:0], SI};
		nbits_d = fresh_q ? 5'h01 : ((frame_q.nbits == LEN_MAX) ? LEN_MAX : frame_q.nbits + 5'h01);
	end

	// Input shifter; state only moves on clock edges so a stopped clock just pauses
	always_ff @(posedge SCK or negedge RESET_N) begin
		if (!RESET_N) begin
			sh_q    <= 8'h00;
			frame_q <= '0;
		end else begin
			sh_q          <= sh_d;
			frame_q.nbits <= nbits_d;
			if (nbits_d == LEN_ONE_BYTE) begin
				frame_q.b0 <= sh_d;
			end
			if (nbits_d == LEN_TWO_BYTES) begin
				frame_q.b1 <= sh_d;
			end
			if (nbits_d == LEN_THREE_BYTES) begin
				frame_q.b2 <= sh_d;
			end
		end
	end

	assign so_clr = CS_KICK_N | ~RESET_N;
	assign rd_off = LEN_READ_END - frame_q.nbits;
	assign rd_idx = rd_off[2:0];

	// Output shifter on falling edges, released when select is high
	always_ff @(negedge SCK or posedge so_clr) begin
		if (so_clr) begin
			SO_O  <= 1'b0;
			SO_OE <= 1'b0;
		end else begin
			SO_OE <= 1'b1;
			if ((frame_q.nbits >= LEN_ONE_BYTE) && (frame_q.nbits <= LEN_READ_END)
				&& (frame_q.b0 == OP_READ_TIMEOUT)) begin
				SO_O <= read_byte_q[rd_idx];
			end else begin
				SO_O <= 1'b0;
			end
		end
	end

endmodule
